// ---- sgpr_pcs_model.sv ----
/* Model of the far SGMII device as seen on the PCS event pins.
   Assumes the bench calls send from one process at a time. */
`timescale 1ns/1ns
module sgpr_pcs_model (
  input wire logic ref_clk,
  output logic pcs_cw_seen,
  output logic pcs_ack_seen,
  output logic pcs_sync_lost,
  output logic pcs_res_valid,
  output logic pcs_res_link,
  output logic [1:0] pcs_res_speed,
  output logic pcs_res_duplex
);
  initial begin
    {pcs_cw_seen, pcs_ack_seen, pcs_sync_lost, pcs_res_valid} = 4'h0;
    {pcs_res_link, pcs_res_speed, pcs_res_duplex} = 4'h0;
  end
  ////////////////////////////////////////
  // Result fields flip once the pulse is over, so a late latch shows garbage.
  task automatic send(input logic [3:0] ev, input logic [3:0] res, input int gap);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    {pcs_cw_seen, pcs_ack_seen, pcs_sync_lost, pcs_res_valid} <= ev;
    {pcs_res_link, pcs_res_speed, pcs_res_duplex} <= res;
    @(posedge ref_clk);
    {pcs_cw_seen, pcs_ack_seen, pcs_sync_lost, pcs_res_valid} <= 4'h0;
    {pcs_res_link, pcs_res_speed, pcs_res_duplex} <= ~res;
  endtask : send
endmodule : sgpr_pcs_model

// ---- sgpr_pkg.sv ----
/*
 * Constants and types of the indirect SGMII PCS register set.
 * Assumes a 21-bit indirect address space and 16-bit register words.
 */
package sgpr_pkg;

  localparam int AW = 21;
  localparam int DW = 16;

  // Indirect register addresses.
  localparam logic [AW-1:0] ADDR_STS = 21'h1f0001;
  localparam logic [AW-1:0] ADDR_ID_HI = 21'h1f0002;
  localparam logic [AW-1:0] ADDR_ID_LO = 21'h1f0003;
  localparam logic [AW-1:0] ADDR_ADV = 21'h1f0004;
  localparam logic [AW-1:0] ADDR_DIG = 21'h1f8000;
  localparam logic [AW-1:0] ADDR_CTL = 21'h1f8001;
  localparam logic [AW-1:0] ADDR_RES = 21'h1f8002;

  // Communication status word.
  localparam logic [9:0] STS_FIXED_HI = 10'h006;
  localparam int STS_FIXED_LSB = 6;
  localparam int STS_DONE_BIT = 5;
  localparam int STS_DET_BIT = 2;

  // Advertisement word: only the masked bits hold state.
  localparam logic [DW-1:0] ADV_MASK = 16'h31e0;
  localparam logic [DW-1:0] ADV_RST = 16'h0020;

  // Digital loop control word.
  localparam logic [DW-1:0] DIG_RST = 16'h2400;
  localparam int DIG_LOOP_BIT = 14;

  // Negotiation control word.
  localparam logic [DW-1:0] CTL_MASK = 16'h001f;
  localparam logic [DW-1:0] CTL_RST = 16'h0004;
  localparam int CTL_INTEN_BIT = 0;
  localparam int CTL_MODE_LSB = 1;
  localparam int CTL_ROLE_BIT = 3;
  localparam int CTL_LINK_BIT = 4;

  // Negotiation result word.
  localparam int RES_LINK_BIT = 4;
  localparam int RES_SPD_LSB = 2;
  localparam int RES_DUP_BIT = 1;

  // Speed codes and the single legal PCS mode.
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  localparam logic [1:0] PCS_SGMII = 2'h2;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_STS, SEL_ID_HI, SEL_ID_LO, SEL_ADV, SEL_DIG, SEL_CTL, SEL_RES
  } sgpr_sel_t;

  // Negotiation progress, Gray coded along idle, detected, complete.
  typedef enum logic [1:0] {
    TRK_IDLE = 2'h0,
    TRK_SEEN = 2'h1,
    TRK_DONE = 2'h3
  } sgpr_trk_t;

endpackage : sgpr_pkg

// ---- sgpr_regs.sv ----
/*
 * Indirect SGMII PCS register set of one external MAC port.
 * Assumes the port portal turns software access into single-cycle
 * read and write strobes on ref_clk, and that PCS events come from
 * logic on the same clock.
 */
`timescale 1ns/1ns
module sgpr_regs #(
  // Arbitrary identification values.
  parameter logic [15:0] ID_HI = 16'h0a5c,
  parameter logic [15:0] ID_LO = 16'h3e10
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [20:0] acc_addr,
  input wire logic [15:0] acc_wdata,
  input wire logic acc_wr,
  input wire logic acc_rd,
  output logic [15:0] acc_rdata,
  output logic acc_rvalid,
  input wire logic pcs_cw_seen,
  input wire logic pcs_ack_seen,
  input wire logic pcs_sync_lost,
  input wire logic pcs_res_valid,
  input wire logic pcs_res_link,
  input wire logic [1:0] pcs_res_speed,
  input wire logic pcs_res_duplex,
  output logic loopback_en,
  output logic role_phy_side,
  output logic link_up_force,
  output logic [1:0] pcs_mode,
  output logic an_done_int
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic [15:0] adv;
    logic [15:0] dig;
    logic [15:0] ctl;
    logic [15:0] rdata;
    logic rvalid;
    logic intr;
  } sgpr_state_t;

  sgpr_state_t r;
  sgpr_state_t next_r;

  sgpr_sts_if sts ();

  ////////////////////////////////////////////////////////////////////////////

  // Full 21-bit compare, so aliases of the map answer as unmapped.
  function automatic sgpr_pkg::sgpr_sel_t sgpr_decode(input logic [20:0] a);
    sgpr_pkg::sgpr_sel_t s;
    s = sgpr_pkg::SEL_NONE;
    case (a)
      sgpr_pkg::ADDR_STS: s = sgpr_pkg::SEL_STS;
      sgpr_pkg::ADDR_ID_HI: s = sgpr_pkg::SEL_ID_HI;
      sgpr_pkg::ADDR_ID_LO: s = sgpr_pkg::SEL_ID_LO;
      sgpr_pkg::ADDR_ADV: s = sgpr_pkg::SEL_ADV;
      sgpr_pkg::ADDR_DIG: s = sgpr_pkg::SEL_DIG;
      sgpr_pkg::ADDR_CTL: s = sgpr_pkg::SEL_CTL;
      sgpr_pkg::ADDR_RES: s = sgpr_pkg::SEL_RES;
      default: s = sgpr_pkg::SEL_NONE;
    endcase
    return s;
  endfunction : sgpr_decode

  // Status word carries the fixed high field and partner codeword activity: detect and complete from the tracker.
  function automatic logic [15:0] sgpr_sts_word(input logic det, input logic done);
    logic [15:0] w;
    w = '0;
    w[15:sgpr_pkg::STS_FIXED_LSB] = sgpr_pkg::STS_FIXED_HI;
    w[sgpr_pkg::STS_DONE_BIT] = done;
    w[sgpr_pkg::STS_DET_BIT] = det;
    return w;
  endfunction : sgpr_sts_word

  function automatic logic [15:0] sgpr_res_word(
    input logic lnk,
    input logic [1:0] spd,
    input logic dup
  );
    logic [15:0] w;
    w = '0;
    w[sgpr_pkg::RES_LINK_BIT] = lnk;
    w[sgpr_pkg::RES_SPD_LSB +: 2] = spd;
    w[sgpr_pkg::RES_DUP_BIT] = dup;
    return w;
  endfunction : sgpr_res_word

  ////////////////////////////////////////////////////////////////////////////

  assign sts.cw_seen = pcs_cw_seen;
  assign sts.ack_seen = pcs_ack_seen;
  assign sts.sync_lost = pcs_sync_lost;
  assign sts.res_valid = pcs_res_valid;
  assign sts.res_link = pcs_res_link;
  assign sts.res_speed = pcs_res_speed;
  assign sts.res_duplex = pcs_res_duplex;

  sgpr_status_track u_track (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ce(ce),
    .sts(sts)
  );

  ////////////////////////////////////////////////////////////////////////////

  logic [15:0] rd_word;
  sgpr_pkg::sgpr_sel_t rd_sel;
  sgpr_pkg::sgpr_sel_t wr_sel;

  assign rd_sel = sgpr_decode(acc_addr);
  assign wr_sel = sgpr_decode(acc_addr);

  // Unmapped reads return zero; the read still completes.
  always_comb begin
    rd_word = '0;
    case (rd_sel)
      sgpr_pkg::SEL_STS: begin
        rd_word = sgpr_sts_word(sts.detect, sts.complete);
      end
      sgpr_pkg::SEL_ID_HI: begin
        rd_word = ID_HI;
      end
      sgpr_pkg::SEL_ID_LO: begin
        rd_word = ID_LO;
      end
      sgpr_pkg::SEL_ADV: begin
        rd_word = r.adv;
      end
      sgpr_pkg::SEL_DIG: begin
        rd_word = r.dig;
      end
      sgpr_pkg::SEL_CTL: begin
        rd_word = r.ctl;
      end
      sgpr_pkg::SEL_RES: begin
        rd_word = sgpr_res_word(sts.part_link, sts.part_speed, sts.part_duplex);
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////

  // Read data shows the value before a write in the same cycle.
  always_comb begin
    next_r = r;
    next_r.rvalid = acc_rd;
    if (acc_rd) begin
      next_r.rdata = rd_word;
    end
    if (acc_wr) begin
      case (wr_sel)
        sgpr_pkg::SEL_ADV: begin
          next_r.adv = acc_wdata & sgpr_pkg::ADV_MASK;
        end
        sgpr_pkg::SEL_DIG: begin
          next_r.dig = acc_wdata;
        end
        sgpr_pkg::SEL_CTL: begin
          next_r.ctl = acc_wdata & sgpr_pkg::CTL_MASK;
        end
        default: begin
          next_r.adv = r.adv;
        end
      endcase
    end
    // The level follows the enable, so a completed negotiation
    // with the enable turned on later still raises it.
    next_r.intr = r.ctl[sgpr_pkg::CTL_INTEN_BIT] & sts.complete;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '{
        adv: sgpr_pkg::ADV_RST,
        dig: sgpr_pkg::DIG_RST,
        ctl: sgpr_pkg::CTL_RST,
        rdata: 16'h0000,
        rvalid: 1'b0,
        intr: 1'b0
      };
    end else if (ce) begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Mode codes other than SGMII are passed through unchanged; the
  // PCS is expected to treat them as reserved.
  assign acc_rdata = r.rdata;
  assign acc_rvalid = r.rvalid;
  assign loopback_en = r.dig[sgpr_pkg::DIG_LOOP_BIT];
  assign role_phy_side = r.ctl[sgpr_pkg::CTL_ROLE_BIT];
  assign link_up_force = r.ctl[sgpr_pkg::CTL_LINK_BIT];
  assign pcs_mode = r.ctl[sgpr_pkg::CTL_MODE_LSB +: 2];
  assign an_done_int = r.intr;

endmodule : sgpr_regs

// ---- sgpr_regs_chk.sv ----
/* Port checker of the indirect SGMII PCS register set.
   Assumes one clock domain; ce may drop, so answers are judged only after a live edge. */
`timescale 1ns/1ns
module sgpr_regs_chk #(
  parameter logic [15:0] ID_HI = 16'h0,
  parameter logic [15:0] ID_LO = 16'h0
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [20:0] acc_addr,
  input wire logic [15:0] acc_wdata,
  input wire logic acc_wr,
  input wire logic acc_rd,
  input wire logic [15:0] acc_rdata,
  input wire logic acc_rvalid,
  input wire logic pcs_ack_seen,
  input wire logic pcs_sync_lost,
  input wire logic loopback_en,
  input wire logic role_phy_side,
  input wire logic link_up_force,
  input wire logic [1:0] pcs_mode,
  input wire logic an_done_int
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  read_answer_a:
    assert property (ce && acc_rd |=> acc_rvalid) else $error("read not answered");
  answer_cause_a:
    assert property ($past(ce) |-> acc_rvalid == $past(acc_rd))
      else $error("answer without read");
  rdata_hold_a:
    assert property (!acc_rd |=> $stable(acc_rdata)) else $error("read data moved");
  status_fixed_a:
    assert property (ce && acc_rd && acc_addr == sgpr_pkg::ADDR_STS |=>
      acc_rdata[15:6] == 10'h006 && acc_rdata[4:3] == 2'h0 && acc_rdata[1:0] == 2'h0)
      else $error("status fixed bits wrong");
  ident_fixed_a:
    assert property (ce && acc_rd && acc_addr[20:1] == sgpr_pkg::ADDR_ID_HI[20:1] |=>
      acc_rdata == ($past(acc_addr[0]) ? ID_LO : ID_HI)) else $error("ident word wrong");
  loop_write_a:
    assert property (ce && acc_wr && acc_addr == sgpr_pkg::ADDR_DIG |=>
      loopback_en == $past(acc_wdata[14])) else $error("loopback not written");
  loop_read_a:
    assert property (ce && acc_rd && acc_addr == sgpr_pkg::ADDR_DIG |=>
      acc_rdata[14] == $past(loopback_en)) else $error("loopback read wrong");
  ctl_write_a:
    assert property (ce && acc_wr && acc_addr == sgpr_pkg::ADDR_CTL |=>
      {link_up_force, role_phy_side, pcs_mode} == $past(acc_wdata[4:1]))
      else $error("control outputs not written");
  ctl_read_a:
    assert property (ce && acc_rd && acc_addr == sgpr_pkg::ADDR_CTL |=>
      acc_rdata[15:1] == {11'h0, $past({link_up_force, role_phy_side, pcs_mode})})
      else $error("control read wrong");
  int_drop_a:
    assert property (ce && pcs_sync_lost && !pcs_ack_seen ##1 ce |=> !an_done_int)
      else $error("interrupt outlived link loss");
endmodule : sgpr_regs_chk

bind sgpr_regs sgpr_regs_chk #(.ID_HI(ID_HI), .ID_LO(ID_LO)) sgpr_regs_chk_i (
  .ref_clk, .nrst, .ce, .acc_addr, .acc_wdata, .acc_wr, .acc_rd, .acc_rdata,
  .acc_rvalid, .pcs_ack_seen, .pcs_sync_lost, .loopback_en, .role_phy_side,
  .link_up_force, .pcs_mode, .an_done_int
);

// ---- sgpr_regs_tb_top.sv ----
/* Self-checking bench of the indirect SGMII PCS register set.
   Assumes the partner model drives every PCS event input. */
`timescale 1ns/1ns
module sgpr_regs_tb_top;
  typedef struct packed {
    logic [20:0] a;
    logic [15:0] w;
    logic [15:0] e;
  } sgpr_row_t;
  logic ref_clk, nrst, ce, acc_wr, acc_rd, acc_rvalid;
  logic [20:0] acc_addr;
  logic [15:0] acc_wdata, acc_rdata, seen;
  logic pcs_cw_seen, pcs_ack_seen, pcs_sync_lost, pcs_res_valid;
  logic pcs_res_link, pcs_res_duplex, loopback_en, role_phy_side;
  logic link_up_force, an_done_int;
  logic [1:0] pcs_res_speed, pcs_mode;
  int failures, compares, cycles;
  sgpr_row_t rows [11];
  // Identification values are arbitrary.
  sgpr_regs #(.ID_HI(16'h5a5a), .ID_LO(16'hc3c3)) sgpr_regs_i (.ref_clk, .nrst,
    .ce, .acc_addr, .acc_wdata, .acc_wr, .acc_rd, .acc_rdata, .acc_rvalid,
    .pcs_cw_seen, .pcs_ack_seen, .pcs_sync_lost, .pcs_res_valid, .pcs_res_link,
    .pcs_res_speed, .pcs_res_duplex, .loopback_en, .role_phy_side,
    .link_up_force, .pcs_mode, .an_done_int);
  sgpr_pcs_model sgpr_pcs_model_i (.ref_clk, .pcs_cw_seen, .pcs_ack_seen,
    .pcs_sync_lost, .pcs_res_valid, .pcs_res_link, .pcs_res_speed, .pcs_res_duplex);
  ////////////////////////////////////////
  task automatic give_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic access(input logic wr, input logic rd, input logic [20:0] a,
                        input logic [15:0] w);
    @(posedge ref_clk);
    acc_wr <= wr;
    acc_rd <= rd;
    acc_addr <= a;
    acc_wdata <= w;
    @(posedge ref_clk);
    acc_wr <= 1'b0;
    acc_rd <= 1'b0;
    @(negedge ref_clk);
    if (rd) begin
      check({15'h0, acc_rvalid}, 16'h0001);
      seen = acc_rdata;
    end
  endtask : access
  task automatic rd(input logic [20:0] a, input logic [15:0] e);
    access(1'b0, 1'b1, a, 16'h0);
    check(seen, e);
  endtask : rd
  task automatic do_reset;
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
  endtask : do_reset
  ////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    nrst <= 1'b0;
    ce <= 1'b1;
    {acc_wr, acc_rd, acc_addr, acc_wdata} <= '0;
    rows = '{
      '{21'h1f0004, 16'hffff, 16'h31e0}, '{21'h1f0004, 16'h0000, 16'h0000},
      '{21'h1f8000, 16'hffff, 16'hffff}, '{21'h1f8000, 16'h0000, 16'h0000},
      '{21'h1f8001, 16'hffff, 16'h001f}, '{21'h1f8001, 16'h0018, 16'h0018},
      '{21'h1f0001, 16'hffff, 16'h0180}, '{21'h1f0002, 16'h0000, 16'h5a5a},
      '{21'h1f0003, 16'h0000, 16'hc3c3}, '{21'h1f8002, 16'hffff, 16'h0000},
      '{21'h1f0005, 16'hffff, 16'h0000}};
    do_reset();
    foreach (rows[i]) begin
      access(1'b1, 1'b0, rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].e);
    end
    // Master setup leaves link-up and role high with interrupts masked.
    check({12'h0, link_up_force, role_phy_side, pcs_mode}, 16'h000c);
    sgpr_pcs_model_i.send(4'h8, 4'h0, 0);
    rd(21'h1f0001, 16'h0184);
    sgpr_pcs_model_i.send(4'h4, 4'h0, 3);
    rd(21'h1f0001, 16'h01a4);
    check({15'h0, an_done_int}, 16'h0000);
    for (int s = 0; s < 4; s++) begin
      sgpr_pcs_model_i.send(4'h1, {1'b1, s[1:0], s[0]}, s);
      rd(21'h1f8002, {11'h0, 1'b1, s[1:0], s[0], 1'b0});
    end
    access(1'b1, 1'b0, 21'h1f8001, 16'h0005);
    rd(21'h1f8001, 16'h0005);
    check({15'h0, an_done_int}, 16'h0001);
    sgpr_pcs_model_i.send(4'h2, 4'h0, 0);
    rd(21'h1f0001, 16'h0180);
    rd(21'h1f8002, 16'h000e);
    check({15'h0, an_done_int}, 16'h0000);
    access(1'b1, 1'b1, 21'h1f8000, 16'h4000);
    check(seen, 16'h0000);
    check({15'h0, loopback_en}, 16'h0001);
    // With the enable low, a write and a codeword must both be lost.
    @(posedge ref_clk);
    ce <= 1'b0;
    access(1'b1, 1'b0, 21'h1f8000, 16'h8000);
    sgpr_pcs_model_i.send(4'h8, 4'h0, 0);
    @(posedge ref_clk);
    ce <= 1'b1;
    rd(21'h1f8000, 16'h4000);
    rd(21'h1f0001, 16'h0180);
    // Acknowledge alone sets detect too; a later codeword drops completion.
    sgpr_pcs_model_i.send(4'h4, 4'h0, 0);
    rd(21'h1f0001, 16'h01a4);
    check({15'h0, an_done_int}, 16'h0001);
    sgpr_pcs_model_i.send(4'h8, 4'h0, 0);
    rd(21'h1f0001, 16'h0184);
    check({15'h0, an_done_int}, 16'h0000);
    // Acknowledge in the same cycle as a loss of sync wins over the clear.
    sgpr_pcs_model_i.send(4'h6, 4'h0, 0);
    rd(21'h1f0001, 16'h01a4);
    do_reset();
    rd(21'h1f0001, 16'h0180);
    rd(21'h1f0004, 16'h0020);
    rd(21'h1f8000, 16'h2400);
    rd(21'h1f8001, 16'h0004);
    rd(21'h1f8002, 16'h0000);
    check({10'h0, loopback_en, role_phy_side, link_up_force, pcs_mode, an_done_int},
          16'h0004);
    give_verdict();
  end
endmodule : sgpr_regs_tb_top

// ---- sgpr_status_track.sv ----
/*
 * Tracks codeword exchange with the partner and holds its result.
 * Assumes event inputs are one-cycle pulses from PCS logic on ref_clk.
 */
`timescale 1ns/1ns
module sgpr_status_track (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  sgpr_sts_if.trk sts
);

  typedef struct packed {
    sgpr_pkg::sgpr_trk_t st;
    logic link;
    logic [1:0] speed;
    logic duplex;
  } sgpr_trk_state_t;

  sgpr_trk_state_t r;
  sgpr_trk_state_t next_r;

  ////////////////////////////////////////////////////////////////////////////

  // A codeword arriving with a loss of sync wins, so no exchange is missed.
  always_comb begin
    next_r = r;
    if (sts.sync_lost) begin
      next_r.st = sgpr_pkg::TRK_IDLE;
      next_r.link = 1'b0;
    end
    case (r.st)
      sgpr_pkg::TRK_IDLE: begin
        if (sts.ack_seen) begin
          next_r.st = sgpr_pkg::TRK_DONE;
        end else if (sts.cw_seen) begin
          next_r.st = sgpr_pkg::TRK_SEEN;
        end
      end
      sgpr_pkg::TRK_SEEN: begin
        if (sts.ack_seen) begin
          next_r.st = sgpr_pkg::TRK_DONE;
        end else if (sts.cw_seen) begin
          next_r.st = sgpr_pkg::TRK_SEEN;
        end
      end
      sgpr_pkg::TRK_DONE: begin
        if (sts.ack_seen) begin
          next_r.st = sgpr_pkg::TRK_DONE;
        end else if (sts.cw_seen) begin
          next_r.st = sgpr_pkg::TRK_SEEN;
        end
      end
      default: begin
        next_r.st = sgpr_pkg::TRK_IDLE;
      end
    endcase
    if (sts.res_valid) begin
      next_r.link = sts.res_link;
      next_r.speed = sts.res_speed;
      next_r.duplex = sts.res_duplex;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '{st: sgpr_pkg::TRK_IDLE, link: 1'b0, speed: sgpr_pkg::SPD_10, duplex: 1'b0};
    end else if (ce) begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign sts.detect = (r.st != sgpr_pkg::TRK_IDLE);
  assign sts.complete = (r.st == sgpr_pkg::TRK_DONE);
  assign sts.part_link = r.link;
  assign sts.part_speed = r.speed;
  assign sts.part_duplex = r.duplex;

endmodule : sgpr_status_track

// ---- sgpr_sts_if.sv ----
/*
 * Carrier between the register front end and the negotiation tracker.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface sgpr_sts_if;
  logic cw_seen;
  logic ack_seen;
  logic sync_lost;
  logic res_valid;
  logic res_link;
  logic [1:0] res_speed;
  logic res_duplex;
  logic detect;
  logic complete;
  logic part_link;
  logic [1:0] part_speed;
  logic part_duplex;

  modport trk (
    input cw_seen, ack_seen, sync_lost, res_valid, res_link, res_speed, res_duplex,
    output detect, complete, part_link, part_speed, part_duplex
  );
  modport regs (
    output cw_seen, ack_seen, sync_lost, res_valid, res_link, res_speed, res_duplex,
    input detect, complete, part_link, part_speed, part_duplex
  );
endinterface : sgpr_sts_if
